/* verilog/acs_pkg.sv */
// shared constants and types for the converter sequencer
package acs_pkg;
   localparam int RES_W     = 10;
   localparam int NUM_RES   = 8;
   localparam int REF_W     = 8;
   localparam int DEB_W     = 7;
   localparam int IDX_W     = 3;
   localparam int WAIT_W    = 16;
   localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
   localparam logic [IDX_W-1:0] CH_VOLT  = 3'h0;
   localparam logic [IDX_W-1:0] CH_TEMP  = 3'h1;
   localparam logic [IDX_W-1:0] CH_CURR  = 3'h2;
   localparam logic [IDX_W-1:0] CH_SUPPLY_INPUT_VOLTAGE  = 3'h3;
   localparam logic [IDX_W-1:0] CH_AUX1  = 3'h6;
   localparam logic [IDX_W-1:0] CH_AUX2  = 3'h7;
   localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 16'h0000;
   localparam logic [DEB_W-1:0] DEB_ZERO = 7'h00;
   typedef enum logic [1:0] {SEQ_SINGLE, SEQ_EIGHT, SEQ_ALL, SEQ_ACPWR} acs_seq_t;
   typedef enum logic [1:0] {CSRC_VOLT, CSRC_TEMP, CSRC_CURR, CSRC_AUX} acs_csrc_t;
   typedef enum logic [1:0] {PH_0, PH_90, PH_180, PH_270} acs_phase_t;
endpackage : acs_pkg

/* verilog/acs_cmp_if.sv */
// results bundle between sequencer and comparators
`timescale 1ns/1ns
`default_nettype none
interface acs_cmp_if;
   logic                                         upd;
   logic [acs_pkg::NUM_RES-1:0][acs_pkg::RES_W-1:0] res;
   logic                                         chan_mode;
   modport src (output upd, output res, output chan_mode);
   modport dst (input upd, input res, input chan_mode);
endinterface : acs_cmp_if
`default_nettype wire

/* verilog/acs_comparator.sv */
// one digital threshold comparator with debounce
`timescale 1ns/1ns
`default_nettype none
module acs_comparator (
   // clock and reset
   input  wire logic            core_clk_i,
   input  wire logic            nrst_i,
   input  wire logic            ce_i,
   // result stream
   acs_cmp_if.dst               rbus,
   // configuration
   input  wire acs_pkg::acs_csrc_t src_i,
   input  wire logic [acs_pkg::IDX_W-1:0] aux_idx_i,
   input  wire logic [acs_pkg::REF_W-1:0] ref_i,
   input  wire logic            deb_en_i,
   input  wire logic            deb_rise_i,
   input  wire logic [acs_pkg::DEB_W-1:0] debounce_count_i,
   // status
   output logic                 sense_o,
   output logic                 irq_o
);
   logic [acs_pkg::DEB_W-1:0] cnt_r;
   logic                      sense_r;
   logic                      irq_r;
   wire  [acs_pkg::IDX_W-1:0] sel_idx =
      (src_i == acs_pkg::CSRC_VOLT) ? acs_pkg::CH_VOLT :
      (src_i == acs_pkg::CSRC_TEMP) ? acs_pkg::CH_TEMP :
      (src_i == acs_pkg::CSRC_CURR) ? acs_pkg::CH_CURR : aux_idx_i;
   // upper 8 bits of the result against the reference
   wire        raw      = rbus.res[sel_idx][acs_pkg::RES_W-1 -: acs_pkg::REF_W] > ref_i;
   wire        diff     = raw != sense_r;
   wire        edge_ok  = raw ? deb_rise_i : ~deb_rise_i;
   wire        done_cnt = cnt_r + 7'h01 >= debounce_count_i;
   wire        take     = rbus.upd & rbus.chan_mode & diff &
                          (~deb_en_i | (cnt_r != acs_pkg::DEB_ZERO | edge_ok ? done_cnt : 1'b0));
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cnt_r   <= acs_pkg::DEB_ZERO;
         sense_r <= 1'b0;
         irq_r   <= 1'b0;
      end else if (ce_i) begin
         irq_r <= take;
         if (take) begin
            sense_r <= raw;
            cnt_r   <= acs_pkg::DEB_ZERO;
         end else if (rbus.upd && rbus.chan_mode) begin
            // any unstable sample restarts the count
            cnt_r <= (diff && deb_en_i && (edge_ok || cnt_r != acs_pkg::DEB_ZERO)) ?
                     cnt_r + 7'h01 : acs_pkg::DEB_ZERO;
         end
      end
   end
   assign sense_o = sense_r;
   assign irq_o   = irq_r;
endmodule : acs_comparator
`default_nettype wire

/* verilog/acs_sequencer.sv */
// converter sequencer, result registers, comparators and safety trip
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
   parameter int WAIT_W = acs_pkg::WAIT_W
) (
   // clock, reset, enable
   input  wire logic                         core_clk_i,
   input  wire logic                         nrst_i,
   input  wire logic                         ce_i,
   // mode control
   input  wire logic                         auto_mode_i,
   input  wire acs_pkg::acs_seq_t            seq_sel_i,
   input  wire logic [acs_pkg::IDX_W-1:0]    chan_sel_i,
   input  wire logic                         host_trig_i,
   input  wire logic                         sleep_request_pin_i,
   input  wire logic [WAIT_W-1:0]            wait_cycles_i,
   input  wire logic [WAIT_W-1:0]            auto_repeat_interval_i,
   input  wire logic                         auto_done_irq_en_i,
   input  wire logic                         off_in_sleep_i,
   input  wire logic                         osc_valid_i,
   // host read tracking
   input  wire logic                         host_read_busy_i,
   input  wire logic                         host_stop_i,
   // converter core
   output logic                              core_en_o,
   output logic                              conv_start_o,
   output logic [acs_pkg::IDX_W-1:0]         conv_chan_o,
   output logic                              conv_ac_o,
   input  wire logic                         conv_done_i,
   input  wire logic [acs_pkg::RES_W-1:0]    conv_data_i,
   // results
   output logic [acs_pkg::NUM_RES*acs_pkg::RES_W-1:0] results_o,
   output logic                              results_signed_o,
   output logic                              done_irq_o,
   output logic                              busy_o,
   // comparators
   input  wire acs_pkg::acs_csrc_t           cmpa_src_i,
   input  wire acs_pkg::acs_csrc_t           cmpb_src_i,
   input  wire logic [acs_pkg::REF_W-1:0]    cmpa_ref_i,
   input  wire logic [acs_pkg::REF_W-1:0]    cmpb_ref_i,
   input  wire logic [1:0]                   deb_en_i,
   input  wire logic [1:0]                   deb_rise_i,
   input  wire logic [acs_pkg::DEB_W-1:0]    debounce_count_a_i,
   input  wire logic [acs_pkg::DEB_W-1:0]    debounce_count_b_i,
   output logic [1:0]                        cmp_sense_o,
   output logic [1:0]                        cmp_irq_o,
   // thermistor and supply scaling
   input  wire logic                         therm_low_i,
   input  wire logic                         therm_trip_en_i,
   input  wire logic                         therm_shut_en_i,
   input  wire logic                         pullup_sleep_off_i,
   input  wire logic                         pullup_never_i,
   input  wire logic                         supply_input_voltage_scale_cmd_i,
   output logic                              therm_irq_o,
   output logic                              boost_rampdown_o,
   output logic                              pa_disable_o,
   output logic                              therm_pullup_en_o,
   output logic                              supply_input_voltage_scale_en_o,
   // mixer phase
   input  wire acs_pkg::acs_phase_t          mix_phase_i,
   output logic [3:0]                        mix_clk_o
);
   typedef enum logic [2:0] {S_IDLE, S_WAIT, S_START, S_CONV, S_COMMIT, S_RATE} acs_state_t;

   acs_state_t                               state_r;
   logic [WAIT_W-1:0]                        tmr_r;
   logic [acs_pkg::IDX_W-1:0]                idx_r;
   logic [1:0]                               seq_r;
   logic [acs_pkg::IDX_W-1:0]                chan_r;
   logic                                     auto_r;
   logic [acs_pkg::NUM_RES-1:0][acs_pkg::RES_W-1:0] shadow_r;
   logic [acs_pkg::NUM_RES-1:0][acs_pkg::RES_W-1:0] res_r;
   logic                                     pend_r;
   logic                                     pend_chan_r;
   logic                                     signed_r;
   logic                                     pend_signed_r;
   logic                                     done_irq_r;
   logic                                     slp_q_r;
   logic                                     therm_q_r;
   logic                                     therm_irq_r;
   logic                                     shut_r;
   logic [1:0]                               mix_cnt_r;

   acs_cmp_if cbus ();

   // either direction of the sleep pin counts as activity
   wire slp_edge   = sleep_request_pin_i ^ slp_q_r;
   wire slp_enter  = sleep_request_pin_i & ~slp_q_r;
   wire run_ok     = ce_i & osc_valid_i;
   wire trig       = host_trig_i | slp_edge;
   wire is_ac      = seq_r == acs_pkg::SEQ_ACPWR;
   wire chan_seq   = seq_r == acs_pkg::SEQ_ALL;
   wire last_conv  = idx_r == acs_pkg::LAST_IDX & seq_r != acs_pkg::SEQ_SINGLE;
   wire single_end = seq_r == acs_pkg::SEQ_SINGLE;
   wire seq_end    = conv_done_i & (last_conv | single_end);
   wire wait_done  = tmr_r == acs_pkg::WAIT_ZERO;
   // store index: channel seq by channel, single by its channel, else in order
   wire [acs_pkg::IDX_W-1:0] store_idx =
      (seq_r == acs_pkg::SEQ_SINGLE) ? chan_r : idx_r;
   wire commit_ok  = pend_r & ~host_read_busy_i;
   wire set_pend   = state_r == S_COMMIT && run_ok;
   wire clear_res  = slp_enter & off_in_sleep_i;
   // auto mode only offers the two full sequences
   wire acs_pkg::acs_seq_t seq_eff =
      (auto_mode_i && seq_sel_i != acs_pkg::SEQ_ACPWR) ? acs_pkg::SEQ_ALL : seq_sel_i;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state_r    <= S_IDLE;
         tmr_r      <= acs_pkg::WAIT_ZERO;
         idx_r      <= '0;
         seq_r      <= acs_pkg::SEQ_SINGLE;
         chan_r     <= '0;
         auto_r     <= 1'b0;
         done_irq_r <= 1'b0;
      end else if (run_ok) begin
         done_irq_r <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (auto_mode_i || trig) begin
                  state_r <= S_WAIT;
                  tmr_r   <= wait_cycles_i;
                  seq_r   <= seq_eff;
                  chan_r  <= chan_sel_i;
                  auto_r  <= auto_mode_i;
                  idx_r   <= '0;
               end
            end
            S_WAIT: begin
               // new triggers are not looked at until idle again
               if (wait_done) state_r <= S_START;
               else tmr_r <= tmr_r - WAIT_W'(1);
            end
            S_START: state_r <= S_CONV;
            S_CONV: begin
               if (seq_end) begin
                  state_r <= S_COMMIT;
               end else if (conv_done_i) begin
                  idx_r   <= idx_r + 3'h1;
                  state_r <= S_START;
               end
            end
            S_COMMIT: begin
               done_irq_r <= ~auto_r | auto_done_irq_en_i;
               if (auto_r) begin
                  state_r <= S_RATE;
                  tmr_r   <= auto_repeat_interval_i;
               end else begin
                  state_r <= S_IDLE;
               end
            end
            S_RATE: begin
               // repeats skip the settling wait; core powers up again at START
               if (!auto_mode_i) state_r <= S_IDLE;
               else if (wait_done) begin
                  state_r <= S_START;
                  seq_r   <= seq_eff;
                  idx_r   <= '0;
               end else tmr_r <= tmr_r - WAIT_W'(1);
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         shadow_r    <= '0;
         res_r       <= '0;
         pend_r      <= 1'b0;
         pend_chan_r <= 1'b0;
         signed_r    <= 1'b0;
         pend_signed_r <= 1'b0;
         slp_q_r     <= 1'b0;
      end else if (ce_i) begin
         slp_q_r <= sleep_request_pin_i;
         if (state_r == S_CONV && conv_done_i && run_ok)
            shadow_r[store_idx] <= conv_data_i;
         if (clear_res) begin
            res_r  <= '0;
            pend_r <= 1'b0;
         end else if (set_pend) begin
            // a fresh set wins; an older pending commit waits one cycle
            pend_r      <= 1'b1;
            // the all-channel and AC sets map each register to one channel; only the all-channel set sets chan_mode
            pend_chan_r <= chan_seq;
            pend_signed_r <= is_ac;
         end else if (commit_ok) begin
            res_r    <= shadow_r;
            signed_r <= pend_signed_r;
            pend_r   <= 1'b0;
         end
      end
   end

   // a deferred commit lands on the stop; busy already low then
   wire cmp_upd = commit_ok & ~clear_res & ~set_pend & (host_stop_i | ~host_read_busy_i);

   assign cbus.upd       = cmp_upd;
   assign cbus.res       = shadow_r;
   assign cbus.chan_mode = pend_chan_r;

   // aux pins only reachable by their own comparator
   acs_comparator u_cmp_a (
      .core_clk_i       (core_clk_i),
      .nrst_i           (nrst_i),
      .ce_i             (ce_i),
      .rbus             (cbus),
      .src_i            (cmpa_src_i),
      .aux_idx_i        (acs_pkg::CH_AUX1),
      .ref_i            (cmpa_ref_i),
      .deb_en_i         (deb_en_i[0]),
      .deb_rise_i       (deb_rise_i[0]),
      .debounce_count_i (debounce_count_a_i),
      .sense_o          (cmp_sense_o[0]),
      .irq_o            (cmp_irq_o[0])
   );
   acs_comparator u_cmp_b (
      .core_clk_i       (core_clk_i),
      .nrst_i           (nrst_i),
      .ce_i             (ce_i),
      .rbus             (cbus),
      .src_i            (cmpb_src_i),
      .aux_idx_i        (acs_pkg::CH_AUX2),
      .ref_i            (cmpb_ref_i),
      .deb_en_i         (deb_en_i[1]),
      .deb_rise_i       (deb_rise_i[1]),
      .debounce_count_i (debounce_count_b_i),
      .sense_o          (cmp_sense_o[1]),
      .irq_o            (cmp_irq_o[1])
   );

   // thermistor trip and mixer phase counter
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         therm_q_r   <= 1'b0;
         therm_irq_r <= 1'b0;
         shut_r      <= 1'b0;
         mix_cnt_r   <= 2'h0;
      end else if (ce_i) begin
         therm_q_r   <= therm_low_i & therm_trip_en_i;
         therm_irq_r <= therm_low_i & therm_trip_en_i & ~therm_q_r;
         // shutdown holds while the trip stands
         shut_r      <= therm_low_i & therm_trip_en_i & therm_shut_en_i;
         mix_cnt_r   <= mix_cnt_r + 2'h1;
      end
   end

   // A leads; B offset by the selected quarter period, only I or Q pairs
   wire [1:0] b_cnt  = mix_cnt_r - mix_phase_i;
   wire       clk_a  = ~mix_cnt_r[1];
   wire       clk_b  = ~b_cnt[1];
   wire       ac_on  = state_r != S_IDLE && is_ac;

   assign mix_clk_o         = ac_on ? {~clk_b, clk_b, ~clk_a, clk_a} : 4'h0;
   // core stays powered across START/CONV turnarounds of a multi-sample set
   assign core_en_o         = state_r == S_WAIT || state_r == S_START || state_r == S_CONV;
   assign conv_start_o      = state_r == S_START && run_ok;
   assign conv_chan_o       = (seq_r == acs_pkg::SEQ_SINGLE || seq_r == acs_pkg::SEQ_EIGHT) ?
                              chan_r : idx_r;
   assign conv_ac_o         = is_ac;
   assign busy_o            = state_r != S_IDLE;
   assign done_irq_o        = done_irq_r;
   assign results_o         = res_r;
   assign results_signed_o  = signed_r;
   assign therm_irq_o       = therm_irq_r;
   assign boost_rampdown_o  = shut_r;
   assign pa_disable_o      = shut_r;
   assign therm_pullup_en_o = ~pullup_never_i & ~(pullup_sleep_off_i & sleep_request_pin_i);
   assign supply_input_voltage_scale_en_o   = supply_input_voltage_scale_cmd_i & (state_r == S_CONV || state_r == S_START) &
                              conv_chan_o == acs_pkg::CH_SUPPLY_INPUT_VOLTAGE & ~is_ac;
endmodule : acs_sequencer
`default_nettype wire

/* tb/acs_core_model.sv */
// behavioural converter core answering each start after a set latency
`timescale 1ns/1ns
`default_nettype none
module acs_core_model (
   // clock and core control
   input  wire logic       clk_i,
   input  wire logic       core_en_i,
   input  wire logic       start_i,
   input  wire logic [2:0] chan_i,
   // result shaping
   input  wire logic [9:0] base_i,
   input  wire logic [3:0] lat_i,
   // answer
   output logic            done_o = 1'b0,
   output logic [9:0]      data_o
);
   logic       run_r  = 1'b0;
   logic [3:0] cnt_r  = 4'h0;
   logic [2:0] smp_r  = 3'h0;
   logic [9:0] data_r = 10'h000;
   logic [9:0] val;
   // value tells sample number and channel apart, so misplaced stores show
   assign val = base_i + {smp_r, 4'h0} + {7'h00, chan_i};
   // inverted outside the done cycle so a late sample never matches
   assign data_o = done_o ? data_r : ~data_r;
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (!core_en_i) smp_r <= 3'h0;
      if (start_i) begin
         run_r <= 1'b1;
         cnt_r <= lat_i;
      end else if (run_r && cnt_r == 4'h0) begin
         run_r  <= 1'b0;
         done_o <= 1'b1;
         data_r <= val;
         smp_r  <= smp_r + 3'h1;
      end else if (run_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule : acs_core_model
`default_nettype wire

/* tb/acs_sequencer_chk.sv */
// port assertions for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_chk (
   // inputs watched
   input wire logic        core_clk_i, nrst_i, ce_i, osc_valid_i, host_trig_i,
   input wire logic        host_read_busy_i, supply_input_voltage_scale_cmd_i, pullup_never_i,
   input wire logic        therm_low_i, therm_trip_en_i, therm_shut_en_i,
   // outputs watched
   input wire logic        busy_o, core_en_o, conv_start_o, conv_ac_o, done_irq_o,
   input wire logic        supply_input_voltage_scale_en_o, therm_irq_o, boost_rampdown_o, pa_disable_o,
   input wire logic        therm_pullup_en_o,
   input wire logic [79:0] results_o,
   input wire logic [1:0]  cmp_sense_o,
   input wire logic [1:0]  cmp_irq_o,
   input wire logic [3:0]  mix_clk_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   trig_taken_a: assert property (!busy_o && host_trig_i && ce_i && osc_valid_i |=> busy_o)
      else $error("idle trigger not taken");
   start_pulse_a: assert property (conv_start_o && ce_i |=> !conv_start_o)
      else $error("start longer than one cycle");
   start_power_a: assert property (conv_start_o |-> core_en_o && busy_o && osc_valid_i)
      else $error("start without powered core");
   idle_off_a: assert property (!busy_o |-> !core_en_o && mix_clk_o == 4'h0)
      else $error("core or mixer active while idle");
   done_after_a: assert property (done_irq_o |-> !$past(core_en_o) ##1 !done_irq_o)
      else $error("done not after power down or too long");
   scale_gate_a: assert property (supply_input_voltage_scale_en_o |-> supply_input_voltage_scale_cmd_i && core_en_o)
      else $error("scaling network on without command");
   mix_phase_a: assert property (conv_ac_o && conv_start_o |->
      mix_clk_o[0] != mix_clk_o[1] && mix_clk_o[2] != mix_clk_o[3])
      else $error("mixer rails not opposite");
   trip_irq_a: assert property (therm_irq_o |-> $past(therm_low_i) && $past(therm_trip_en_i))
      else $error("trip interrupt without cause");
   trip_shut_a: assert property (pa_disable_o |-> boost_rampdown_o &&
      $past(therm_low_i && therm_shut_en_i))
      else $error("shutdown without trip");
   sense_irq_a: assert property (cmp_sense_o[0] != $past(cmp_sense_o[0]) |-> cmp_irq_o[0])
      else $error("sense change without interrupt");
   read_hold_a: assert property (!$stable(results_o) && results_o != 80'h0 |->
      !$past(host_read_busy_i))
      else $error("results changed during host read");
   pullup_off_a: assert property (pullup_never_i |-> !therm_pullup_en_o)
      else $error("pull-up on while never selected");
endmodule : acs_sequencer_chk
`default_nettype wire

/* tb/acs_sequencer_tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb_top;
   localparam logic [15:0] WAITC = 16'h0005;
   logic core_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, osc_valid_i = 1'b1;
   logic auto_mode_i = 1'b0, host_trig_i = 1'b0, sleep_request_pin_i = 1'b0;
   logic auto_done_irq_en_i = 1'b1, off_in_sleep_i = 1'b0, host_read_busy_i = 1'b0;
   logic host_stop_i = 1'b0, therm_low_i = 1'b0, therm_trip_en_i = 1'b1, therm_shut_en_i = 1'b1;
   logic pullup_sleep_off_i = 1'b0, pullup_never_i = 1'b0, supply_input_voltage_scale_cmd_i = 1'b1;
   acs_pkg::acs_seq_t   seq_sel_i = acs_pkg::SEQ_SINGLE;
   logic [2:0]          chan_sel_i = 3'h0;
   logic [15:0]         wait_cycles_i = WAITC, auto_repeat_interval_i = 16'h0014;
   acs_pkg::acs_csrc_t  cmpa_src_i = acs_pkg::CSRC_VOLT, cmpb_src_i = acs_pkg::CSRC_AUX;
   logic [7:0]          cmpa_ref_i = 8'h10, cmpb_ref_i = 8'h50;
   logic [1:0]          deb_en_i = 2'h0, deb_rise_i = 2'h0;
   logic [6:0]          debounce_count_a_i = 7'h03, debounce_count_b_i = 7'h03;
   acs_pkg::acs_phase_t mix_phase_i = acs_pkg::PH_90;
   logic conv_done_i, core_en_o, conv_start_o, conv_ac_o, results_signed_o, done_irq_o, busy_o;
   logic therm_irq_o, boost_rampdown_o, pa_disable_o, therm_pullup_en_o, supply_input_voltage_scale_en_o;
   logic [2:0]  conv_chan_o;
   logic [9:0]  conv_data_i, base = 10'h100;
   logic [79:0] results_o, snap;
   logic [1:0]  cmp_sense_o, cmp_irq_o;
   logic [3:0]  mix_clk_o;
   logic        supply_input_voltage_seen = 1'b0, tirq_seen = 1'b0;
   logic [1:0]  cirq_seen = 2'b00;
   int          mismatches = 0, cmp_count = 0, starts = 0, s0, n, k;

   always #25 core_clk_i = ~core_clk_i;
   acs_sequencer u_acs_sequencer (.*);
   acs_core_model u_acs_core_model (.clk_i(core_clk_i), .core_en_i(core_en_o),
      .start_i(conv_start_o), .chan_i(conv_chan_o), .base_i(base), .lat_i(4'h3),
      .done_o(conv_done_i), .data_o(conv_data_i));
   always @(negedge core_clk_i) begin
      if (conv_start_o === 1'b1) starts++;
      if (supply_input_voltage_scale_en_o === 1'b1) supply_input_voltage_seen = 1'b1;
      if (therm_irq_o === 1'b1) tirq_seen = 1'b1;
      if (cmp_irq_o[0] === 1'b1) cirq_seen[0] = 1'b1;
      if (cmp_irq_o[1] === 1'b1) cirq_seen[1] = 1'b1;
   end

   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // sel 1 waits for done, sel 0 for idle
   task automatic wait_sig(input bit sel);
      int i;
      for (i = 0; i < 3000 && (sel ? done_irq_o !== 1'b1 : busy_o !== 1'b0); i++)
         @(negedge core_clk_i);
      if (i == 3000) begin
         mismatches++;
         print_verdict();
      end
      // results land one cycle after the done pulse
      if (sel) @(negedge core_clk_i);
   endtask : wait_sig
   task automatic run(input acs_pkg::acs_seq_t s, input logic [2:0] c, output int lat);
      @(posedge core_clk_i);
      seq_sel_i <= s;
      chan_sel_i <= c;
      host_trig_i <= 1'b1;
      @(posedge core_clk_i) host_trig_i <= 1'b0;
      lat = 0;
      do begin
         @(negedge core_clk_i);
         lat++;
      end while (lat < 100 && conv_start_o !== 1'b1);
      if (lat == 100) begin
         mismatches++;
         print_verdict();
      end
   endtask : run

   initial begin
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      run(acs_pkg::SEQ_SINGLE, 3'h3, n);
      chk(n, WAITC + 16'h2);
      wait_sig(1);
      for (k = 0; k < 8; k++) chk(results_o[k*10+:10], k == 3 ? base + 10'h3 : 10'h0);
      chk(supply_input_voltage_seen, 1'b1);
      s0 = starts;
      run(acs_pkg::SEQ_EIGHT, 3'h1, n);
      @(posedge core_clk_i) host_trig_i <= 1'b1;
      @(posedge core_clk_i) host_trig_i <= 1'b0;
      wait_sig(1);
      for (k = 0; k < 8; k++) chk(results_o[k*10+:10], base + 10'(16 * k + 1));
      repeat (4) @(negedge core_clk_i);
      chk({starts - s0, busy_o}, {32'd8, 1'b0});
      run(acs_pkg::SEQ_ALL, 3'h0, n);
      wait_sig(1);
      for (k = 0; k < 8; k++) chk(results_o[k*10+:10], base + 10'(17 * k));
      repeat (2) @(negedge core_clk_i);
      chk({cmp_sense_o, cirq_seen}, 4'b1111);
      run(acs_pkg::SEQ_ACPWR, 3'h0, n);
      wait_sig(1);
      @(negedge core_clk_i);
      chk(results_signed_o, 1'b1);
      // no valid oscillator: a trigger must not be taken
      @(posedge core_clk_i);
      osc_valid_i <= 1'b0;
      host_trig_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      osc_valid_i <= 1'b1;
      host_trig_i <= 1'b0;
      @(negedge core_clk_i) chk(busy_o, 1'b0);
      // auto repeats the AC sequence; two completions in a row
      @(posedge core_clk_i) auto_mode_i <= 1'b1;
      wait_sig(1);
      @(negedge core_clk_i);
      wait_sig(1);
      chk(core_en_o, 1'b0);
      @(posedge core_clk_i) auto_mode_i <= 1'b0;
      wait_sig(0);
      snap = results_o;
      @(posedge core_clk_i);
      host_read_busy_i <= 1'b1;
      base <= 10'h200;
      run(acs_pkg::SEQ_SINGLE, 3'h0, n);
      wait_sig(1);
      repeat (3) @(negedge core_clk_i);
      chk(results_o, snap);
      @(posedge core_clk_i);
      host_read_busy_i <= 1'b0;
      host_stop_i <= 1'b1;
      @(posedge core_clk_i) host_stop_i <= 1'b0;
      repeat (3) @(negedge core_clk_i);
      chk(results_o[9:0], 10'h200);
      @(posedge core_clk_i);
      therm_low_i <= 1'b1;
      pullup_never_i <= 1'b1;
      repeat (3) @(negedge core_clk_i);
      chk({boost_rampdown_o, pa_disable_o, tirq_seen, therm_pullup_en_o}, 4'b1110);
      // sleep pin edges trigger; pull-up follows the sleep signal
      @(posedge core_clk_i);
      pullup_never_i <= 1'b0;
      pullup_sleep_off_i <= 1'b1;
      base <= 10'h300;
      sleep_request_pin_i <= 1'b1;
      wait_sig(1);
      repeat (3) @(negedge core_clk_i);
      chk({results_o[9:0], therm_pullup_en_o}, {10'h300, 1'b0});
      @(posedge core_clk_i) sleep_request_pin_i <= 1'b0;
      wait_sig(1);
      repeat (3) @(negedge core_clk_i);
      @(posedge core_clk_i);
      off_in_sleep_i <= 1'b1;
      sleep_request_pin_i <= 1'b1;
      repeat (3) @(negedge core_clk_i);
      chk(results_o, 80'h0);
      print_verdict();
   end
endmodule : acs_sequencer_tb_top
bind acs_sequencer acs_sequencer_chk u_acs_sequencer_chk (.*);
`default_nettype wire
